// file: core/clf_pkg.sv
// Shared constants and types for the current-loop limit and feedback scaler
package clf_pkg;
	localparam int DIV_W = 40;
	localparam logic [1:0] SRC_NETWORK = 2'h1;
	localparam logic [1:0] SEL_PI_LIMITS = 2'h1;
	localparam logic [1:0] SEL_REGISTER = 2'h2;
	localparam logic [23:0] ALARM_SIGN_FLIP = 24'ha00052;
	// Bounds in 0.1 % of full load amps, signed
	localparam logic signed [15:0] UPPER_RESET = 16'sh05dc;
	localparam logic signed [15:0] LOWER_RESET = 16'sh05dc;
	// Gains in thousandths, combined gain limits in millionths
	localparam logic [15:0] TRIM_MIN = 16'h0384;
	localparam logic [15:0] TRIM_MAX = 16'h044c;
	localparam logic [15:0] TRIM_UNITY = 16'h03e8;
	localparam logic [15:0] SCALE_RESET = 16'h03e8;
	localparam logic [21:0] GAIN_MIN = 22'h0c3500;
	localparam logic [21:0] GAIN_MAX = 22'h1e8480;
	localparam logic [39:0] GAIN_MIN_NUM = 40'h00000c3500;
	localparam logic [39:0] GAIN_MAX_NUM = 40'h00001e8480;
	localparam logic signed [39:0] GAIN_DIV = 40'sh00000f4240;
	// Full-scale 3000 mV times unity gain, and 3000 mV alone
	localparam logic [23:0] FULL_SCALE_NUM = 24'h2dc6c0;
	localparam logic [15:0] FULL_SCALE_MV = 16'h0bb8;
	localparam int BURDEN_N = 4;
	localparam logic [7:0] BURDEN_OHMS [BURDEN_N] = '{8'h0f, 8'h14, 8'h1e, 8'h27};
	localparam logic [2:0] BURDEN_FIRST = 3'h1;
	// Third edge after release is the first with a synced jumper level
	localparam logic [1:0] WARM_DONE = 2'h3;
	typedef enum logic [3:0] {
		CALC_IDLE = 4'b0001,
		CALC_SCALE = 4'b0010,
		CALC_HI = 4'b0100,
		CALC_LO = 4'b1000
	} clf_calc_e;
endpackage

// file: core/clf_div_if.sv
// Request and answer between the scaler and its divider
`timescale 1ns/100ps
interface clf_div_if;
	logic start;
	logic [clf_pkg::DIV_W-1:0] dividend;
	logic [clf_pkg::DIV_W-1:0] divisor;
	logic busy;
	logic done;
	logic [clf_pkg::DIV_W-1:0] quotient;
	modport requester(output start, output dividend, output divisor,
		input busy, input done, input quotient);
	modport divider(input start, input dividend, input divisor,
		output busy, output done, output quotient);
endinterface

// file: core/clf_divider.sv
// Iterative restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module clf_divider (
	input wire logic clock,
	input wire logic rst_n,
	clf_div_if.divider div
);
	localparam int W = clf_pkg::DIV_W;
	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] count;
		logic [W-1:0] rem;
		logic [W-1:0] quo;
		logic [W-1:0] den;
	} clf_div_s;
	clf_div_s st;
	clf_div_s next_st;
	logic [W:0] trial;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		trial = {st.rem, st.quo[W-1]};
		if (st.busy) begin
			if (trial >= {1'b0, st.den}) begin
				trial = trial - {1'b0, st.den};
				next_st.quo = {st.quo[W-2:0], 1'b1};
			end else begin
				next_st.quo = {st.quo[W-2:0], 1'b0};
			end
			next_st.rem = trial[W-1:0];
			next_st.count = st.count - 6'h01;
			if (st.count == 6'h01) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end else if (div.start) begin
			next_st.busy = 1'b1;
			next_st.count = 6'(W);
			next_st.rem = '0;
			next_st.quo = div.dividend;
			next_st.den = div.divisor;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Zero divisor yields all ones, which the caller saturates
	assign div.busy = st.busy;
	assign div.done = st.done;
	assign div.quotient = st.quo;
endmodule

// file: core/clf_scaler.sv
// Current-loop limit sign handling, wind direction and feedback scaling
// Operation
// - Inversion enabled: both bounds accept positives only
// - Inversion disabled: lower bound negative only
// - Inversion change raises alarm with code
// - Inversion change forces both selectors to register
// - Inversion change negates stored lower bound
// - Current mode uses and shows torque reference
// - Underwind bit inverts speed feedback and reference
// - Underwind resets zero, network-only access
// - Leaving network source clears underwind bit
// - Software scale computed, 3 V equals maximum
// - Trim 0.900 to 1.100, reset 1.000
// - Trim bounds, then a gain clamp, keep gain within 0.800..2.000
// - Publish fully scaled current feedback
// - Burden position is one of four
// - Position 1..4 from ratio, current, amps
`timescale 1ns/100ps
module clf_scaler (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic current_mode_pin,
	input wire logic sign_flip_wr,
	input wire logic sign_flip_val,
	input wire logic upper_bound_wr,
	input wire logic lower_bound_wr,
	input wire logic signed [15:0] bound_val,
	input wire logic upper_sel_wr,
	input wire logic lower_sel_wr,
	input wire logic [1:0] sel_val,
	input wire logic underwind_wr,
	input wire logic underwind_val,
	input wire logic from_network,
	input wire logic [1:0] control_source,
	input wire logic network_map_choice,
	input wire logic trim_wr,
	input wire logic [15:0] trim_val,
	input wire logic [15:0] transformer_ratio,
	input wire logic [15:0] rated_amps,
	input wire logic [7:0] max_current_pct,
	input wire logic signed [15:0] torque_reference,
	input wire logic signed [15:0] speed_loop_output,
	input wire logic signed [15:0] speed_feedback_raw,
	input wire logic signed [15:0] current_feedback_raw,
	output logic negative_limit_sign_flip_enable,
	output logic signed [15:0] upper_current_bound,
	output logic signed [15:0] lower_current_bound,
	output logic [1:0] upper_bound_source_select,
	output logic [1:0] lower_bound_source_select,
	output logic alarm_event,
	output logic [23:0] alarm_code,
	output logic write_refused,
	output logic underwind_enable,
	output logic current_mode,
	output logic signed [15:0] torque_reference_view,
	output logic signed [15:0] loop_reference,
	output logic signed [15:0] speed_feedback,
	output logic [15:0] software_scale,
	output logic [15:0] feedback_trim_gain,
	output logic [21:0] combined_gain,
	output logic signed [15:0] scaled_current_feedback,
	output logic [2:0] burden_position_hint
);
	typedef struct packed {
		logic [1:0] mode_sync;
		logic [1:0] warm;
		logic mode;
		logic flip;
		logic signed [15:0] upper;
		logic signed [15:0] lower;
		logic [1:0] upper_sel;
		logic [1:0] lower_sel;
		logic alarm;
		logic refused;
		logic underwind;
		logic [1:0] last_src;
		logic [15:0] trim;
		logic [39:0] seen;
		logic [15:0] scale;
		logic [15:0] trim_hi;
		logic [15:0] trim_lo;
		logic [2:0] burden;
		clf_pkg::clf_calc_e calc;
		logic issued;
		logic [21:0] gain;
		logic signed [15:0] fb;
		logic signed [15:0] ref_out;
		logic signed [15:0] spd_out;
	} clf_state_s;
	clf_state_s st;
	clf_state_s next_st;
	clf_div_if div_bus();

	logic [23:0] imax;
	logic [31:0] den_sel;
	logic [2:0] pos_sel;
	logic [39:0] inputs_now;
	logic [15:0] lo_b;
	logic [15:0] hi_b;
	logic [15:0] trim_eff;
	logic [31:0] gain_raw;
	logic signed [39:0] fb_wide;
	logic [15:0] quo_sat;
	logic flip_change;

	clf_divider u_div (
		.clock(clock),
		.rst_n(rst_n),
		.div(div_bus)
	);

	// Largest burden that keeps max current at or under full scale
	always_comb begin
		imax = 24'(rated_amps) * 24'(max_current_pct);
		pos_sel = clf_pkg::BURDEN_FIRST;
		den_sel = 32'(imax) * 32'(clf_pkg::BURDEN_OHMS[0]);
		for (int p = 0; p < clf_pkg::BURDEN_N; p++) begin
			if (32'(imax) * 32'(clf_pkg::BURDEN_OHMS[p]) <=
				32'(transformer_ratio) * 32'(clf_pkg::FULL_SCALE_MV)) begin
				pos_sel = 3'(p + 1);
				den_sel = 32'(imax) * 32'(clf_pkg::BURDEN_OHMS[p]);
			end
		end
	end

	assign inputs_now = {transformer_ratio, rated_amps, max_current_pct};
	assign div_bus.start = (st.calc != clf_pkg::CALC_IDLE) && !st.issued && !div_bus.busy;
	always_comb begin
		div_bus.dividend = clf_pkg::GAIN_MAX_NUM;
		div_bus.divisor = 40'(st.scale);
		if (st.calc == clf_pkg::CALC_SCALE) begin
			div_bus.dividend = 40'(transformer_ratio) * 40'(clf_pkg::FULL_SCALE_NUM);
			div_bus.divisor = 40'(den_sel);
		end else if (st.calc == clf_pkg::CALC_LO) begin
			// Rounded up so the product never drops below the floor
			div_bus.dividend = clf_pkg::GAIN_MIN_NUM + 40'(st.scale) - 40'h1;
		end
	end
	assign quo_sat = (div_bus.quotient > 40'h000000ffff) ? 16'hffff : div_bus.quotient[15:0];

	// Trim bounds from the product limits, then clamp, then use
	always_comb begin
		lo_b = (st.trim_lo > clf_pkg::TRIM_MIN) ? st.trim_lo : clf_pkg::TRIM_MIN;
		hi_b = (st.trim_hi < clf_pkg::TRIM_MAX) ? st.trim_hi : clf_pkg::TRIM_MAX;
		trim_eff = st.trim;
		if (st.trim > hi_b) begin
			trim_eff = hi_b;
		end
		if (trim_eff < lo_b) begin
			trim_eff = lo_b;
		end
		gain_raw = 32'(st.scale) * 32'(trim_eff);
		fb_wide = 40'(current_feedback_raw) * $signed({18'h0, st.gain}) / clf_pkg::GAIN_DIV;
	end

	assign flip_change = sign_flip_wr && (sign_flip_val != st.flip);

	always_comb begin
		next_st = st;
		next_st.alarm = 1'b0;
		next_st.refused = 1'b0;
		next_st.mode_sync = {st.mode_sync[0], current_mode_pin};
		// Jumper is latched once after each reset release, never followed later
		if (st.warm != clf_pkg::WARM_DONE) begin
			next_st.warm = st.warm + 2'h1;
			next_st.mode = st.mode_sync[1];
		end
		if (flip_change) begin
			next_st.flip = sign_flip_val;
			next_st.alarm = 1'b1;
			next_st.upper_sel = clf_pkg::SEL_REGISTER;
			next_st.lower_sel = clf_pkg::SEL_REGISTER;
			next_st.lower = -st.lower;
		end else begin
			if (upper_bound_wr) begin
				if (st.flip && bound_val < 0) begin
					next_st.refused = 1'b1;
				end else begin
					next_st.upper = bound_val;
				end
			end
			if (lower_bound_wr) begin
				if ((st.flip && bound_val < 0) || (!st.flip && bound_val > 0)) begin
					next_st.refused = 1'b1;
				end else begin
					next_st.lower = bound_val;
				end
			end
			if (upper_sel_wr) begin
				next_st.upper_sel = sel_val;
			end
			if (lower_sel_wr) begin
				next_st.lower_sel = sel_val;
			end
		end
		if (underwind_wr) begin
			if (from_network) begin
				next_st.underwind = underwind_val;
			end else begin
				next_st.refused = 1'b1;
			end
		end
		next_st.last_src = control_source;
		// Revert beats a write in the same cycle
		if (st.last_src == clf_pkg::SRC_NETWORK && control_source != clf_pkg::SRC_NETWORK) begin
			next_st.underwind = 1'b0;
		end
		if (trim_wr) begin
			if (trim_val < clf_pkg::TRIM_MIN || trim_val > clf_pkg::TRIM_MAX) begin
				next_st.refused = 1'b1;
			end else begin
				next_st.trim = trim_val;
			end
		end
		// A change mid-sequence is caught on return to idle
		unique case (st.calc)
			clf_pkg::CALC_IDLE: begin
				if (inputs_now != st.seen) begin
					next_st.seen = inputs_now;
					next_st.burden = pos_sel;
					next_st.calc = clf_pkg::CALC_SCALE;
				end
			end
			clf_pkg::CALC_SCALE, clf_pkg::CALC_HI, clf_pkg::CALC_LO: begin
				if (div_bus.start) begin
					next_st.issued = 1'b1;
				end
				if (div_bus.done) begin
					next_st.issued = 1'b0;
					if (st.calc == clf_pkg::CALC_SCALE) begin
						next_st.scale = (quo_sat == 16'h0) ? 16'h1 : quo_sat;
						next_st.calc = clf_pkg::CALC_HI;
					end else if (st.calc == clf_pkg::CALC_HI) begin
						next_st.trim_hi = quo_sat;
						next_st.calc = clf_pkg::CALC_LO;
					end else begin
						next_st.trim_lo = quo_sat;
						next_st.calc = clf_pkg::CALC_IDLE;
					end
				end
			end
			default: next_st.calc = clf_pkg::CALC_IDLE;
		endcase
		if (gain_raw < 32'(clf_pkg::GAIN_MIN)) begin
			next_st.gain = clf_pkg::GAIN_MIN;
		end else if (gain_raw > 32'(clf_pkg::GAIN_MAX)) begin
			next_st.gain = clf_pkg::GAIN_MAX;
		end else begin
			next_st.gain = gain_raw[21:0];
		end
		if (fb_wide > 40'sh0000007fff) begin
			next_st.fb = 16'sh7fff;
		end else if (fb_wide < -40'sh0000008000) begin
			next_st.fb = -16'sh8000;
		end else begin
			next_st.fb = fb_wide[15:0];
		end
		next_st.ref_out = st.mode ? torque_reference : speed_loop_output;
		if (st.underwind) begin
			next_st.ref_out = -next_st.ref_out;
			next_st.spd_out = -speed_feedback_raw;
		end else begin
			next_st.spd_out = speed_feedback_raw;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '{mode_sync: 2'h0, warm: 2'h0, mode: 1'b0, flip: 1'b1,
				upper: clf_pkg::UPPER_RESET, lower: clf_pkg::LOWER_RESET,
				upper_sel: clf_pkg::SEL_PI_LIMITS, lower_sel: clf_pkg::SEL_PI_LIMITS,
				alarm: 1'b0, refused: 1'b0, underwind: 1'b0, last_src: 2'h0,
				trim: clf_pkg::TRIM_UNITY, seen: 40'h0, scale: clf_pkg::SCALE_RESET,
				trim_hi: clf_pkg::TRIM_MAX, trim_lo: clf_pkg::TRIM_MIN,
				burden: clf_pkg::BURDEN_FIRST, calc: clf_pkg::CALC_IDLE, issued: 1'b0,
				gain: 22'h0f4240, fb: 16'sh0, ref_out: 16'sh0, spd_out: 16'sh0};
		end else begin
			st <= next_st;
		end
	end

	assign negative_limit_sign_flip_enable = st.flip;
	assign upper_current_bound = st.upper;
	assign lower_current_bound = st.lower;
	assign upper_bound_source_select = st.upper_sel;
	assign lower_bound_source_select = st.lower_sel;
	assign alarm_event = st.alarm;
	assign alarm_code = clf_pkg::ALARM_SIGN_FLIP;
	assign write_refused = st.refused;
	assign underwind_enable = st.underwind;
	assign current_mode = st.mode;
	assign torque_reference_view = torque_reference;
	assign loop_reference = st.ref_out;
	assign speed_feedback = st.spd_out;
	assign software_scale = st.scale;
	assign feedback_trim_gain = st.trim;
	assign combined_gain = st.gain;
	assign scaled_current_feedback = st.fb;
	assign burden_position_hint = st.burden;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence flip_req;
		sign_flip_wr && (sign_flip_val != negative_limit_sign_flip_enable);
	endsequence
	chk_flip_alarm: assert property (flip_req |=> alarm_event)
		else $error("alarm missing after sign flip change");
	chk_alarm_only_flip: assert property (!flip_req |=> !alarm_event)
		else $error("alarm without sign flip change");
	chk_flip_selects: assert property (flip_req |=> upper_bound_source_select ==
		clf_pkg::SEL_REGISTER && lower_bound_source_select == clf_pkg::SEL_REGISTER)
		else $error("selectors not forced to register");
	chk_flip_negate: assert property (flip_req |=> lower_current_bound ==
		-$past(lower_current_bound))
		else $error("lower bound not negated");
	chk_bound_positive: assert property (negative_limit_sign_flip_enable && !$past(flip_change)
		|-> upper_current_bound >= 0 && lower_current_bound >= 0)
		else $error("negative bound while inversion enabled");
	chk_lower_negative: assert property (!negative_limit_sign_flip_enable && !$past(flip_change)
		|-> lower_current_bound <= 0)
		else $error("positive lower bound while inversion disabled");
	chk_underwind_revert: assert property (st.last_src == clf_pkg::SRC_NETWORK &&
		control_source != clf_pkg::SRC_NETWORK |=> !underwind_enable ##1
		(!underwind_enable || $past(underwind_wr && from_network)))
		else $error("underwind not cleared on source change");
	chk_underwind_invert: assert property (underwind_enable |=>
		speed_feedback == -$past(speed_feedback_raw))
		else $error("speed feedback not inverted");
	chk_trim_range: assert property (feedback_trim_gain >= clf_pkg::TRIM_MIN &&
		feedback_trim_gain <= clf_pkg::TRIM_MAX)
		else $error("trim out of range");
	chk_gain_range: assert property (##1 combined_gain >= clf_pkg::GAIN_MIN &&
		combined_gain <= clf_pkg::GAIN_MAX)
		else $error("combined gain out of range");
	chk_burden_range: assert property (burden_position_hint >= 3'h1 &&
		burden_position_hint <= 3'h4)
		else $error("burden position out of range");
endmodule

// file: testbench/clf_master_model.sv
// Keypad and network master stand-in that issues configuration writes
`timescale 1ns/100ps
module clf_master_model (
	input wire logic clock,
	output logic sign_flip_wr,
	output logic sign_flip_val,
	output logic upper_bound_wr,
	output logic lower_bound_wr,
	output logic signed [15:0] bound_val,
	output logic upper_sel_wr,
	output logic lower_sel_wr,
	output logic [1:0] sel_val,
	output logic underwind_wr,
	output logic underwind_val,
	output logic from_network,
	output logic [1:0] control_source,
	output logic network_map_choice,
	output logic trim_wr,
	output logic [15:0] trim_val
);
	initial begin
		{sign_flip_wr, upper_bound_wr, lower_bound_wr, upper_sel_wr, lower_sel_wr} = '0;
		{underwind_wr, trim_wr, from_network, network_map_choice} = '0;
		{sign_flip_val, underwind_val} = 2'h0;
		control_source = 2'h0;
		sel_val = 2'h0;
		bound_val = 16'sh0000;
		trim_val = 16'h0000;
	end

	// Kinds: 0 flip, 1/2 upper/lower bound, 3/4 upper/lower selector,
	// 5 underwind over network, 6 underwind from keypad, 7 control source, 8 trim
	task automatic put(input int k, input logic signed [15:0] v);
		if (k == 5) begin
			@(posedge clock);
			control_source <= clf_pkg::SRC_NETWORK;
			network_map_choice <= 1'b1;
		end
		@(posedge clock);
		from_network <= (k == 5);
		bound_val <= v;
		sel_val <= v[1:0];
		trim_val <= v;
		underwind_val <= v[0];
		sign_flip_val <= v[0];
		case (k)
			0: sign_flip_wr <= 1'b1;
			1: upper_bound_wr <= 1'b1;
			2: lower_bound_wr <= 1'b1;
			3: upper_sel_wr <= 1'b1;
			4: lower_sel_wr <= 1'b1;
			5, 6: underwind_wr <= 1'b1;
			7: control_source <= v[1:0];
			default: trim_wr <= 1'b1;
		endcase
		@(posedge clock);
		{sign_flip_wr, upper_bound_wr, lower_bound_wr, upper_sel_wr, lower_sel_wr} <= '0;
		{underwind_wr, trim_wr} <= 2'h0;
		// Released data lines must not look like valid values
		bound_val <= ~v;
		trim_val <= ~v;
		sel_val <= ~v[1:0];
		underwind_val <= ~v[0];
		sign_flip_val <= ~v[0];
	endtask
endmodule

// file: testbench/clf_scaler_tb_top.sv
// Self-checking bench for the current-loop limit and feedback scaler
`timescale 1ns/100ps
module clf_scaler_tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic current_mode_pin = 1'b0;
	logic sign_flip_wr, sign_flip_val, upper_bound_wr, lower_bound_wr;
	logic upper_sel_wr, lower_sel_wr, underwind_wr, underwind_val;
	logic from_network, network_map_choice, trim_wr;
	logic signed [15:0] bound_val;
	logic [1:0] sel_val, control_source;
	logic [15:0] trim_val;
	logic [15:0] transformer_ratio = 16'h008b;
	logic [15:0] rated_amps = 16'h0064;
	logic [7:0] max_current_pct = 8'h96;
	logic signed [15:0] torque_reference = -16'sh02bc;
	logic signed [15:0] speed_loop_output = 16'sh00c8;
	logic signed [15:0] speed_feedback_raw = 16'sh012c;
	logic signed [15:0] current_feedback_raw = 16'sh03e8;
	logic negative_limit_sign_flip_enable, alarm_event, write_refused;
	logic underwind_enable, current_mode;
	logic signed [15:0] upper_current_bound, lower_current_bound, torque_reference_view;
	logic signed [15:0] loop_reference, speed_feedback, scaled_current_feedback;
	logic [1:0] upper_bound_source_select, lower_bound_source_select;
	logic [23:0] alarm_code;
	logic [15:0] software_scale, feedback_trim_gain;
	logic [21:0] combined_gain;
	logic [2:0] burden_position_hint;
	// Ratio 139 with these currents lands on positions 2, 3 and 4
	logic [15:0] amps_t [3] = '{16'h0064, 16'h0050, 16'h0037};
	logic [7:0] pct_t [3] = '{8'h96, 8'h96, 8'h64};
	logic [2:0] pos_t [3] = '{3'h2, 3'h3, 3'h4};
	logic [15:0] scale_t [3] = '{16'h056e, 16'h0486, 16'h0798};
	int err_count = 0;
	int cmp_count = 0;

	clf_scaler dut (.*);
	clf_master_model master (.*);

	always #2.5 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input int k, input int v);
		master.put(k, v[15:0]);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		// Mode jumper settles on the third edge, reference one edge later
		step(5);
	endtask

	// Divider chain has no done flag, so poll the gain under a bound
	task automatic wait_gain(input logic [31:0] exp);
		int n;
		n = 0;
		while ({10'h000, combined_gain} !== exp && n < 600) begin
			step(1);
			n++;
		end
		step(3);
		chk(combined_gain, exp);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		results();
	end

	initial begin
		do_reset();
		chk(negative_limit_sign_flip_enable, 32'h1);
		chk(upper_current_bound, 16'sh05dc);
		chk(upper_bound_source_select, 32'h1);
		chk(underwind_enable, 32'h0);
		chk(feedback_trim_gain, 16'h03e8);
		chk(alarm_code, 24'ha00052);
		chk(current_mode, 32'h0);
		$display("test reset done");
		wr(1, -16'sh0064);
		chk(write_refused, 32'h1);
		chk(upper_current_bound, 16'sh05dc);
		wr(2, -16'sh0064);
		chk(write_refused, 32'h1);
		wr(1, 16'sh03e8);
		chk(upper_current_bound, 16'sh03e8);
		wr(2, 16'sh04b0);
		chk(lower_current_bound, 16'sh04b0);
		wr(0, 0);
		chk(alarm_event, 32'h1);
		chk(upper_bound_source_select, 32'h2);
		chk(lower_bound_source_select, 32'h2);
		chk(lower_current_bound, -16'sh04b0);
		step(1);
		chk(alarm_event, 32'h0);
		wr(2, 16'sh01f4);
		chk(write_refused, 32'h1);
		chk(lower_current_bound, -16'sh04b0);
		wr(2, -16'sh012c);
		chk(lower_current_bound, -16'sh012c);
		wr(3, 1);
		wr(4, 1);
		chk(lower_bound_source_select, 32'h1);
		wr(0, 1);
		chk(alarm_event, 32'h1);
		chk(upper_bound_source_select, 32'h2);
		chk(lower_bound_source_select, 32'h2);
		chk(lower_current_bound, 16'sh012c);
		$display("test limits done");
		wr(6, 1);
		chk(write_refused, 32'h1);
		chk(underwind_enable, 32'h0);
		wr(5, 1);
		chk(underwind_enable, 32'h1);
		step(1);
		chk(speed_feedback, -16'sh012c);
		chk(loop_reference, -16'sh00c8);
		wr(7, 0);
		chk(underwind_enable, 32'h0);
		step(1);
		chk(speed_feedback, 16'sh012c);
		chk(loop_reference, 16'sh00c8);
		$display("test underwind done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			rated_amps <= amps_t[i];
			max_current_pct <= pct_t[i];
			wait_gain(32'(scale_t[i]) * 32'h0000_03e8);
			chk(burden_position_hint, pos_t[i]);
			chk(software_scale, scale_t[i]);
			chk(scaled_current_feedback, scale_t[i]);
		end
		wr(8, 16'h044d);
		chk(write_refused, 32'h1);
		wr(8, 16'h0383);
		chk(write_refused, 32'h1);
		wr(8, 16'h044c);
		chk(feedback_trim_gain, 16'h044c);
		// Stored trim 1.100 is held to 1.028 by the 2.000 ceiling
		wait_gain(32'h001e_7e60);
		chk(scaled_current_feedback, 16'sh07ce);
		@(posedge clock);
		current_feedback_raw <= -16'sh03e8;
		step(3);
		chk(scaled_current_feedback, -16'sh07ce);
		$display("test scaling done");
		@(posedge clock);
		current_mode_pin <= 1'b1;
		do_reset();
		chk(current_mode, 32'h1);
		chk(torque_reference_view, -16'sh02bc);
		chk(loop_reference, -16'sh02bc);
		chk(lower_current_bound, 16'sh05dc);
		$display("test torque mode done");
		results();
	end
endmodule
